// File: tb/adcsc_conv_model.sv
// Converter chip model: delayed done edge with a bounded data window
`timescale 1ns/1ps
module adcsc_conv_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control from the block and from the bench
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [15:0] sample,
  // Pins back to the block
  output logic             conv_done_pin,
  output logic [15:0]      conv_data_pin
);
  int          cnt;
  int          lim;
  logic        act;
  logic [15:0] held;

  assign lim = slow ? 60 : 12;

  always @(posedge aclk) begin
    if (!aresetn) begin
      act           <= 1'b0;
      cnt           <= 0;
      conv_done_pin <= 1'b0;
      conv_data_pin <= 16'h5a5a;
    end else if (conv_start && !act) begin
      act  <= 1'b1;
      cnt  <= 0;
      held <= sample;
    end else if (act) begin
      cnt <= cnt + 1;
      if (cnt == lim - 2) conv_data_pin <= held;
      if (cnt == lim) conv_done_pin <= 1'b1;
      if (cnt == lim + 6) begin
        // Data no longer valid: show the inverse
        conv_done_pin <= 1'b0;
        conv_data_pin <= ~held;
        act           <= 1'b0;
      end
    end
  end
endmodule : adcsc_conv_model

// File: tb/tb_adcsc_top.sv
// Testbench: register-level scenarios for the conversion control block
`timescale 1ns/1ps
module tb_adcsc_top;
  import adcsc_pkg::*;
  logic aclk, aresetn, irq, conv_start, conv_done_pin, slow;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] conv_data_pin, sample;
  adcsc_front_type front;
  int err_count, num_checks, i;
  localparam logic [8:0]  SU [4] = '{9'h065, 9'h0df, 9'h03f, 9'h090};
  localparam logic [15:0] SA [4] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff};

  adcsc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .front,
    .conv_start, .conv_done_pin, .conv_data_pin);
  adcsc_conv_model conv (.aclk, .aresetn, .conv_start, .slow, .sample,
    .conv_done_pin, .conv_data_pin);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [9:0] x);
    return {x, 2'b00};
  endfunction : ba

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input string nm);
    err_count++;
    $display("ERROR %s expected answer seen timeout", nm);
    wrap_up();
  endtask : tmo

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 100 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb) tmo("bvalid");
    chk("bresp", er, rs);
  endtask : wr

  task automatic rdr(input logic [11:0] a, input logic [1:0] er);
    logic ta, tr;
    int n;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 100 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr) tmo("rvalid");
    chk("rresp", er, rs);
  endtask : rdr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    rdr(a, RESP_OKAY);
    chk(nm, e, rd);
  endtask : rdc

  task automatic wait_idle(input logic [31:0] m);
    int n;
    rd = m;
    for (n = 0; n < 800 && (rd & m) !== 32'h0; n++) rdr(ba(IDX_STATUS), RESP_OKAY);
    if ((rd & m) !== 32'h0) tmo("status");
  endtask : wait_idle

  // One manual conversion with a setup change while it runs
  task automatic run(input logic [8:0] s, input logic [15:0] v, input logic cr);
    adcsc_front_type fe;
    fe = {~(s[5] & s[4]), s[5], s[4:0], s[7:6]};
    wr(ba(IDX_SETUP), {23'h0, s}, RESP_OKAY);
    rdc(ba(IDX_STATUS), 32'h2, "settling");
    wait_idle(32'h3);
    rdc(ba(IDX_IRQ_STATUS), 32'h2, "irq_settle");
    chk("irq_settle_pin", 32'h1, {31'h0, irq});
    sample <= v;
    slow   <= v[0];
    wr(ba(IDX_TRIGGER), 32'h0000_a5c3, RESP_OKAY);
    rdc(ba(IDX_STATUS), 32'h1, "busy");
    chk("front", {23'h0, fe}, {23'h0, front});
    wr(ba(IDX_SETUP), {23'h0, s ^ 9'h0aa}, RESP_OKAY);
    chk("front_hold", {23'h0, fe}, {23'h0, front});
    wait_idle(32'h1);
    if (cr) rdc(ba(IDX_RESULT), {16'h0, v}, "result");
    chk("irq_done", 32'h1, {31'h0, irq});
    wr(ba(IDX_IRQ_STATUS), 32'h3, RESP_OKAY);
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 12'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    sample = 16'h0;
    slow = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(ba(IDX_SETUP), 32'h0, "setup_rst");
    rdc(ba(IDX_RESULT), 32'h0, "result_rst");
    rdc(ba(IDX_STATUS), 32'h0, "status_rst");
    rdr(12'h7fc, RESP_SLVERR);
    chk("unmapped", 32'h0, rd);
    wr(ba(IDX_RESULT), 32'h1, RESP_SLVERR);
    wr(ba(IDX_STATUS), 32'h3, RESP_SLVERR);
    wr(ba(IDX_IRQ_MASK), 32'h3, RESP_OKAY);
    rdc(ba(IDX_IRQ_MASK), 32'h3, "mask");
    run(9'h003, 16'h1234, 1'b0);
    run(9'h003, 16'h4321, 1'b0);
    for (i = 0; i < 4; i++) run(SU[i], SA[i], 1'b1);
    wait_idle(32'h3);
    wr(ba(IDX_IRQ_STATUS), 32'h3, RESP_OKAY);
    wr(ba(IDX_SEQCTL), 32'h1, RESP_OKAY);
    wr(ba(IDX_TRIGGER), 32'h0, RESP_OKAY);
    rdc(ba(IDX_STATUS), 32'h0, "seq_block");
    wr(ba(IDX_SEQCTL), 32'h0, RESP_OKAY);
    sample <= 16'h8001;
    wr(ba(IDX_SETUP), 32'h105, RESP_OKAY);
    rdr(ba(IDX_STATUS), RESP_OKAY);
    chk("auto_busy", 32'h1, {31'h0, rd[STAT_CONV_BUSY]});
    wait_idle(32'h3);
    rdc(ba(IDX_RESULT), 32'h8001, "auto_result");
    rdc(ba(IDX_IRQ_STATUS), 32'h1, "auto_irq");
    wr(ba(IDX_IRQ_MASK), 32'h0, RESP_OKAY);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(ba(IDX_IRQ_STATUS), 32'h1, RESP_OKAY);
    rdc(ba(IDX_IRQ_STATUS), 32'h0, "irq_w1c");
    wrap_up();
  end
endmodule : tb_adcsc_top

// File: verilog/adcsc_engine.sv
// Conversion engine: settling timer, launch, capture and result coding
`timescale 1ns/1ps
module adcsc_engine
  import adcsc_pkg::*;
(
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // From the register file
  input  wire logic            setup_wr,
  input  wire adcsc_setup_type setup_new,
  input  wire logic            trigger_wr,
  // From the converter, already synchronised
  input  wire logic            done_pulse,
  input  wire logic [15:0]     sample_raw,
  // Status and results
  output logic                 settle_busy,
  output logic                 conv_busy,
  output logic                 settle_evt,
  output logic                 conv_evt,
  output logic                 conv_start,
  output logic [15:0]          result_q,
  output adcsc_setup_type      cfg_q
);

  adcsc_conv_state_type state_q, state_d;
  logic [15:0]          settle_cnt_q, settle_cnt_d;
  logic                 auto_pend_q, auto_pend_d;
  logic [15:0]          result_d;
  adcsc_setup_type      cfg_d;
  logic                 settle_done;
  logic                 launch;

  ////////////////////////////////////////////////////////////////////////////
  // Settling timer
  assign settle_done = (settle_cnt_q == 16'h0001);

  always_comb begin
    settle_cnt_d = settle_cnt_q;
    auto_pend_d  = auto_pend_q;
    if (setup_wr) begin
      settle_cnt_d = SETTLE_CYCLES;
      auto_pend_d  = setup_new.auto_settle;
    end else if (settle_cnt_q != 16'h0000) begin
      settle_cnt_d = settle_cnt_q - 16'h0001;
    end
    if (launch && !setup_wr) begin
      auto_pend_d = 1'b0;
    end
  end

  assign settle_busy = (settle_cnt_q != 16'h0000);
  assign settle_evt  = settle_done && !setup_wr && !auto_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion control
  always_comb begin
    launch = 1'b0;
    if (state_q == CV_IDLE) begin
      launch = (trigger_wr && !auto_pend_q && !settle_busy)
               || (auto_pend_q && settle_cnt_q <= 16'h0001 && !setup_wr);
    end
  end

  always_comb begin
    state_d  = state_q;
    cfg_d    = cfg_q;
    result_d = result_q;
    unique case (state_q)
      CV_IDLE: begin
        if (launch) begin
          state_d = CV_START;
          cfg_d   = setup_new;
        end
      end
      CV_START: begin
        state_d = CV_WAIT;
      end
      CV_WAIT: begin
        if (done_pulse) begin
          state_d  = CV_IDLE;
          result_d = BIPOLAR_RANGE ? sample_raw
                                   : {~sample_raw[15], sample_raw[14:0]};
        end
      end
      default: begin
        state_d = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= CV_IDLE;
      cfg_q        <= adcsc_setup_type'(SETUP_RESET);
      result_q     <= RESULT_RESET;
      settle_cnt_q <= 16'h0000;
      auto_pend_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      cfg_q        <= cfg_d;
      result_q     <= result_d;
      settle_cnt_q <= settle_cnt_d;
      auto_pend_q  <= auto_pend_d;
    end
  end

  assign conv_busy  = (state_q != CV_IDLE);
  assign conv_start = (state_q == CV_START);
  assign conv_evt   = (state_q == CV_WAIT) && done_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_auto_launch;
    @(posedge aclk) disable iff (!aresetn)
    (auto_pend_q && settle_done && !setup_wr && state_q == CV_IDLE)
      |=> (conv_busy && conv_start) ##1 (conv_busy && !conv_start);
  endproperty
  a_auto_launch: assert property (p_auto_launch) else $error("Auto launch missing");

endmodule : adcsc_engine

// File: verilog/adcsc_pkg.sv
// Package: register map, field layout and timing for the conversion control block
package adcsc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0]  IDX_SETUP      = 10'h000;
  localparam logic [9:0]  IDX_RESULT     = 10'h002;
  localparam logic [9:0]  IDX_STATUS     = 10'h004;
  localparam logic [9:0]  IDX_TRIGGER    = 10'h006;
  localparam logic [9:0]  IDX_SEQCTL     = 10'h00a;
  localparam logic [9:0]  IDX_IRQ_STATUS = 10'h010;
  localparam logic [9:0]  IDX_IRQ_MASK   = 10'h012;

  // Setup register field positions
  localparam int          SETUP_CH_LSB   = 0;
  localparam int          SETUP_TOPO_BIT = 5;
  localparam int          SETUP_GAIN_LSB = 6;
  localparam int          SETUP_AUTO_BIT = 8;
  localparam int          SETUP_WIDTH    = 9;

  // Status and interrupt bit positions
  localparam int          STAT_CONV_BUSY   = 0;
  localparam int          STAT_SETTLE_BUSY = 1;
  localparam int          IRQ_CONV_DONE    = 0;
  localparam int          IRQ_SETTLE_DONE  = 1;
  localparam int          SEQCTL_ENABLE    = 0;

  // Reset values
  localparam logic [8:0]  SETUP_RESET    = 9'h000;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam logic        SEQCTL_RESET   = 1'b0;

  // Result coding
  localparam logic        BIPOLAR_RANGE  = 1'b1;

  // Settling interval
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          SETTLE_TIME_NS = 10000;
  localparam logic [15:0] SETTLE_CYCLES  = 16'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);

  // Bus answers
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef struct packed {
    logic       auto_settle;
    logic [1:0] gain;
    logic       input_topology;
    logic [4:0] channel;
  } adcsc_setup_type;

  typedef struct packed {
    logic       mux_enable;
    logic       input_topology;
    logic [4:0] channel;
    logic [1:0] gain;
  } adcsc_front_type;

  typedef enum logic [1:0] {
    CV_IDLE  = 2'b00,
    CV_START = 2'b01,
    CV_WAIT  = 2'b10
  } adcsc_conv_state_type;

endpackage : adcsc_pkg

// File: verilog/adcsc_top.sv
// Top: AXI4-Lite register file, interrupts and converter pins for one conversion
`timescale 1ns/1ps
module adcsc_top
  import adcsc_pkg::*;
(
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Interrupt
  output logic                 irq,
  // Analog front end
  output adcsc_front_type      front,
  // Converter chip
  output logic                 conv_start,
  input  wire logic            conv_done_pin,
  input  wire logic [15:0]     conv_data_pin
);

  logic [11:0]     aw_addr_q, aw_addr_d;
  logic            aw_full_q, aw_full_d;
  logic [31:0]     w_data_q, w_data_d;
  logic [1:0]      w_strb_q, w_strb_d;
  logic            w_full_q, w_full_d;
  logic            bvalid_q, bvalid_d;
  logic [1:0]      bresp_q, bresp_d;
  logic            rvalid_q, rvalid_d;
  logic [31:0]     rdata_q, rdata_d;
  logic [1:0]      rresp_q, rresp_d;
  logic [8:0]      setup_q, setup_d;
  logic            seq_on_q, seq_on_d;
  logic [1:0]      irq_stat_q, irq_stat_d;
  logic [1:0]      irq_mask_q, irq_mask_d;
  logic            done_s1_q, done_s2_q, done_s3_q;
  logic [15:0]     data_s1_q, data_s2_q;
  logic            wr_fire;
  logic [9:0]      wr_idx;
  logic            wr_ok;
  logic            setup_wr, trigger_wr;
  logic            settle_busy, conv_busy, settle_evt, conv_evt, conv_flag;
  logic [15:0]     result;
  adcsc_setup_type cfg;

  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = addr[11:2];
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    reg_mapped = (addr[1:0] == 2'b00) &&
                 (idx == IDX_SETUP || idx == IDX_RESULT || idx == IDX_STATUS ||
                  idx == IDX_TRIGGER || idx == IDX_SEQCTL || idx == IDX_IRQ_STATUS ||
                  idx == IDX_IRQ_MASK);
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= 16'h0000;
      data_s2_q <= 16'h0000;
    end else begin
      done_s1_q <= conv_done_pin;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      data_s1_q <= conv_data_pin;
      data_s2_q <= data_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
  assign wr_idx        = reg_index(aw_addr_q);
  assign wr_ok         = reg_mapped(aw_addr_q) && wr_idx != IDX_RESULT && wr_idx != IDX_STATUS;
  assign setup_wr      = wr_fire && wr_ok && wr_idx == IDX_SETUP && (|w_strb_q);
  assign trigger_wr    = wr_fire && wr_ok && wr_idx == IDX_TRIGGER && !seq_on_q;

  always_comb begin
    aw_addr_d = aw_addr_q;
    aw_full_d = aw_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    w_full_d  = w_full_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_d = s_axi_awaddr;
      aw_full_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb[1:0];
      w_full_d = 1'b1;
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and interrupt flags
  always_comb begin
    setup_d    = setup_q;
    seq_on_d   = seq_on_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (setup_wr) begin
      if (w_strb_q[0]) setup_d[7:0] = w_data_q[7:0];
      if (w_strb_q[1]) setup_d[8]   = w_data_q[SETUP_AUTO_BIT];
    end
    if (wr_fire && wr_ok && wr_idx == IDX_SEQCTL && w_strb_q[0]) begin
      seq_on_d = w_data_q[SEQCTL_ENABLE];
    end
    if (wr_fire && wr_ok && wr_idx == IDX_IRQ_MASK && w_strb_q[0]) begin
      irq_mask_d = w_data_q[1:0];
    end
    if (wr_fire && wr_ok && wr_idx == IDX_IRQ_STATUS && w_strb_q[0]) begin
      irq_stat_d = irq_stat_q & ~w_data_q[1:0];
    end
    if (conv_evt) irq_stat_d[IRQ_CONV_DONE] = 1'b1;
    if (settle_evt) irq_stat_d[IRQ_SETTLE_DONE] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      rresp_d  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (reg_mapped(s_axi_araddr)) begin
        unique case (reg_index(s_axi_araddr))
          IDX_SETUP:      rdata_d[8:0]  = setup_q;
          IDX_RESULT:     rdata_d[15:0] = result;
          IDX_STATUS:     rdata_d[1:0]  = {settle_busy, conv_flag};
          IDX_SEQCTL:     rdata_d[0]    = seq_on_q;
          IDX_IRQ_STATUS: rdata_d[1:0]  = irq_stat_q;
          IDX_IRQ_MASK:   rdata_d[1:0]  = irq_mask_q;
          default:        rdata_d       = 32'h0000_0000;
        endcase
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q  <= 12'h000;
      aw_full_q  <= 1'b0;
      w_data_q   <= 32'h0000_0000;
      w_strb_q   <= 2'h0;
      w_full_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
      setup_q    <= SETUP_RESET;
      seq_on_q   <= SEQCTL_RESET;
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end else begin
      aw_addr_q  <= aw_addr_d;
      aw_full_q  <= aw_full_d;
      w_data_q   <= w_data_d;
      w_strb_q   <= w_strb_d;
      w_full_q   <= w_full_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      setup_q    <= setup_d;
      seq_on_q   <= seq_on_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = |(irq_stat_q & irq_mask_q);
  assign conv_flag     = conv_busy || (setup_q[SETUP_AUTO_BIT] && settle_busy);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion engine and front end
  adcsc_engine u_engine (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .setup_wr    (setup_wr),
    .setup_new   (adcsc_setup_type'(setup_d)),
    .trigger_wr  (trigger_wr),
    .done_pulse  (done_s2_q && !done_s3_q),
    .sample_raw  (data_s2_q),
    .settle_busy (settle_busy),
    .conv_busy   (conv_busy),
    .settle_evt  (settle_evt),
    .conv_evt    (conv_evt),
    .conv_start  (conv_start),
    .result_q    (result),
    .cfg_q       (cfg)
  );

  // Differential pairs on channel sixteen and up select nothing
  assign front.mux_enable     = !(cfg.input_topology && cfg.channel[4]);
  assign front.input_topology = cfg.input_topology;
  assign front.channel        = cfg.channel;
  assign front.gain           = cfg.gain;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [15:0] settle_len_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) settle_len_q <= 16'h0000;
    else          settle_len_q <= (settle_busy && !setup_wr) ? settle_len_q + 16'h0001 : 16'h0000;
  end

  sequence s_status_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {IDX_STATUS, 2'b00};
  endsequence

  property p_status_zero;
    s_status_read |=> (s_axi_rdata[31:2] == 30'h0) && s_axi_rvalid;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("Status high bits set");

  property p_trigger_launch;
    (trigger_wr && !conv_busy && !settle_busy)
      |=> (conv_busy && conv_start) ##1 (conv_busy && !conv_start);
  endproperty
  a_trigger_launch: assert property (p_trigger_launch) else $error("No launch");

  property p_seq_block;
    (wr_fire && wr_idx == IDX_TRIGGER && seq_on_q && !conv_busy && !settle_busy
     && !setup_q[SETUP_AUTO_BIT]) |=> !conv_busy;
  endproperty
  a_seq_block: assert property (p_seq_block) else $error("Trigger not ignored");

  property p_settle_set;
    setup_wr |=> settle_busy;
  endproperty
  a_settle_set: assert property (p_settle_set) else $error("Settling not set");

  property p_settle_len;
    settle_busy |-> settle_len_q < SETTLE_CYCLES;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("Settling too long");

  property p_settle_exact;
    $fell(settle_busy) |-> settle_len_q == SETTLE_CYCLES;
  endproperty
  a_settle_exact: assert property (p_settle_exact) else $error("Settling too short");

  property p_result_stable;
    (conv_busy && $past(conv_busy)) |-> $stable(result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("Result moved");

  property p_cfg_hold;
    (conv_busy && !conv_start) |-> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("Settings moved");

  property p_conv_irq;
    (conv_evt && irq_mask_q[IRQ_CONV_DONE]) |=> irq && !conv_busy;
  endproperty
  a_conv_irq: assert property (p_conv_irq) else $error("Done irq missing");

  property p_diff_invalid;
    (cfg.input_topology && cfg.channel[4]) |-> !front.mux_enable;
  endproperty
  a_diff_invalid: assert property (p_diff_invalid) else $error("Invalid pair chosen");

endmodule : adcsc_top
